// ### tws_pkg.sv
// constants and types for the two-wire register slave
// Function
// RL1 - slave only, any clock up to 400kHz
// RL2 - data line input, open-drain when sending
// RL3 - data stable while clock high
// RL4 - data change during clock high is condition
// RL5 - detect start and stop conditions
// RL6 - repeated start begins new transaction
// RL7 - acknowledge low across ninth clock pulse
// RL8 - no-acknowledge leaves data line released
// RL9 - master retries after missing acknowledge
// RL10 - eight bits msb first, then acknowledge
// RL11 - high byte at even address, sent first
// RL12 - idle watch for start plus address, ack
// RL13 - fixed address 0110110, bytes 6C/6D
// RL14 - direction bit selects write or read
// RL15 - next byte only after acknowledge
// RL16 - acknowledge bare address probe
// RL17 - write: pointer then data bytes, acked
// RL18 - pointer byte loads start location
// RL19 - read: pointer write, repeated start, read
// RL20 - device drives data during read phase
// RL21 - master nack ends read, line released
// RL22 - stop returns interface to idle
// RL23 - pointer increments after each byte
// RL24 - discard writes past address 4Fh
// RL25 - commit only complete two-byte registers
// RL26 - reads past FFh return FFh
// RL27 - synchronise and filter clock and data
`default_nettype none
package tws_pkg;
   localparam logic [6:0] DEV_ADDR      = 7'h36;
   localparam logic [7:0] LAST_WR_ADDR  = 8'h4F;
   localparam logic [7:0] LAST_ADDR     = 8'hFF;
   localparam logic [7:0] PAST_END_BYTE = 8'hFF;
   localparam logic [7:0] PTR_RESET     = 8'h00;
   localparam logic [3:0] BIT_ACK       = 4'h8;
   localparam int         SYNC_STAGES   = 2;
   localparam int         FILTER_LEN    = 3;
   typedef enum logic [2:0] {
      TWS_IDLE, TWS_ADDR, TWS_ACK, TWS_RX, TWS_TX, TWS_MACK, TWS_WAIT
   } tws_state_t;
endpackage
`default_nettype wire

// ### tws_line_filter.sv
// two-flop synchroniser plus glitch filter for one line that changes only when all samples agree
`default_nettype none
module tws_line_filter #(
   parameter int LEN = tws_pkg::FILTER_LEN
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic line_in,
   output var  logic line_out
);
   logic           meta_reg;
   logic           sync_reg;
   logic [LEN-2:0] hist_reg;
   logic [LEN-2:0] hist_next;
   logic [LEN-1:0] win;
   logic           out_reg;
   logic           out_next;

   // newest sample counts, so an answer still fits in a short clock low phase
   always_comb begin
      win       = {hist_reg, sync_reg};
      hist_next = win[LEN-2:0];
      out_next  = out_reg;
      if (&win) begin // see RL27
         out_next = 1'b1;
      end else if (~|win) begin
         out_next = 1'b0;
      end
      line_out  = out_next;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         hist_reg <= '1;
         out_reg  <= 1'b1;
      end else begin
         meta_reg <= line_in;
         sync_reg <= meta_reg;
         hist_reg <= hist_next;
         out_reg  <= out_next;
      end
   end
endmodule
`default_nettype wire

// ### tws_slave.sv
// two-wire slave giving a master access to an 8-bit-addressed register space
`default_nettype none
module tws_slave (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output var  logic       sda_o,
   output var  logic       sda_oe_n,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_rd_addr,
   input  wire logic [7:0] reg_rd_data,
   output var  logic [7:0] reg_wr_addr,
   output var  logic [15:0] reg_wr_data,
   output var  logic       reg_wr_en,
   output var  logic       bus_busy
);
   ////////////////////////////////////////////////////////////////////////////
   // line conditioning and event detection
   logic scl_f;
   logic sda_f;
   logic scl_d_reg;
   logic sda_d_reg;

   tws_line_filter u_scl_filter (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .line_in  (scl_i),
      .line_out (scl_f)
   );
   tws_line_filter u_sda_filter (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .line_in  (sda_i),
      .line_out (sda_f)
   );

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_rise  = scl_f & ~scl_d_reg; // see RL1
   assign scl_fall  = ~scl_f & scl_d_reg;
   // data edges while clock high are conditions, not data
   assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f; // see RL4, RL5
   assign stop_det  = scl_f & scl_d_reg & ~sda_d_reg & sda_f; // see RL4, RL5

   ////////////////////////////////////////////////////////////////////////////
   // protocol engine
   tws_pkg::tws_state_t state_reg;
   tws_pkg::tws_state_t state_next;
   logic [3:0]  bit_reg;
   logic [3:0]  bit_next;
   logic [7:0]  shift_reg;
   logic [7:0]  shift_next;
   logic [7:0]  ptr_reg;
   logic [7:0]  ptr_next;
   logic        ptr_ld_reg;
   logic        ptr_ld_next;
   logic        rd_reg;
   logic        rd_next;
   logic [7:0]  hi_reg;
   logic [7:0]  hi_next;
   logic        hi_ok_reg;
   logic        hi_ok_next;
   logic        ovf_reg;
   logic        ovf_next;
   logic        drv_reg;
   logic        drv_next;
   logic        dbit_reg;
   logic        dbit_next;
   logic        busy_next;
   logic        wr_en_next;
   logic [7:0]  wr_addr_next;
   logic [15:0] wr_data_next;

   function automatic logic [7:0] ptr_inc(input logic [7:0] p, input logic ovf);
      ptr_inc = ovf ? p : p + 8'h01;
   endfunction

   function automatic logic ptr_wraps(input logic [7:0] p, input logic ovf);
      ptr_wraps = ovf | (p == tws_pkg::LAST_ADDR);
   endfunction

   logic [7:0] tx_byte;
   assign tx_byte = ovf_reg ? tws_pkg::PAST_END_BYTE : reg_rd_data; // see RL26

   always_comb begin
      state_next   = state_reg;
      bit_next     = bit_reg;
      shift_next   = shift_reg;
      ptr_next     = ptr_reg;
      ptr_ld_next  = ptr_ld_reg;
      rd_next      = rd_reg;
      hi_next      = hi_reg;
      hi_ok_next   = hi_ok_reg;
      ovf_next     = ovf_reg;
      drv_next     = drv_reg;
      dbit_next    = dbit_reg;
      busy_next    = bus_busy;
      wr_en_next   = 1'b0;
      wr_addr_next = reg_wr_addr;
      wr_data_next = reg_wr_data;
      if (stop_det) begin
         state_next = tws_pkg::TWS_IDLE; // see RL22
         busy_next  = 1'b0;
         drv_next   = 1'b0;
      end else if (start_det) begin
         state_next  = tws_pkg::TWS_ADDR; // see RL6, RL12
         busy_next   = 1'b1;
         bit_next    = 4'h0;
         drv_next    = 1'b0;
         ptr_ld_next = 1'b0; // see RL19
         hi_ok_next  = 1'b0;
      end else begin
         unique case (state_reg)
            tws_pkg::TWS_IDLE, tws_pkg::TWS_WAIT: begin
               if (scl_fall) begin
                  drv_next = 1'b0; // see RL21
               end
            end
            tws_pkg::TWS_ADDR, tws_pkg::TWS_RX: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_f}; // see RL3, RL10
                  bit_next   = bit_reg + 4'h1;
               end
               if (scl_fall && bit_reg == tws_pkg::BIT_ACK) begin
                  bit_next = 4'h0;
                  if (state_reg == tws_pkg::TWS_ADDR) begin
                     if (shift_reg[7:1] == tws_pkg::DEV_ADDR) begin // see RL13
                        rd_next    = shift_reg[0]; // see RL14
                        drv_next   = 1'b1; // see RL12, RL16
                        dbit_next  = 1'b0;
                        state_next = tws_pkg::TWS_ACK;
                     end else begin
                        state_next = tws_pkg::TWS_WAIT;
                     end
                  end else begin
                     drv_next   = 1'b1; // see RL7, RL17
                     dbit_next  = 1'b0;
                     state_next = tws_pkg::TWS_ACK;
                     if (!ptr_ld_reg) begin
                        ptr_next    = shift_reg; // see RL18
                        ptr_ld_next = 1'b1;
                        ovf_next    = 1'b0;
                        hi_ok_next  = 1'b0;
                     end else begin
                        if (!ptr_reg[0]) begin
                           hi_next    = shift_reg; // see RL11
                           hi_ok_next = 1'b1;
                        end else begin
                           // see RL24, RL25
                           if (hi_ok_reg && !ovf_reg && ptr_reg <= tws_pkg::LAST_WR_ADDR) begin
                              wr_en_next   = 1'b1;
                              wr_addr_next = {ptr_reg[7:1], 1'b0};
                              wr_data_next = {hi_reg, shift_reg};
                           end
                           hi_ok_next = 1'b0;
                        end
                        ovf_next = ptr_wraps(ptr_reg, ovf_reg);
                        ptr_next = ptr_inc(ptr_reg, ovf_reg); // see RL23
                     end
                  end
               end
            end
            tws_pkg::TWS_ACK, tws_pkg::TWS_MACK: begin
               // own ack held to the ninth fall; master ack loads the next byte there
               if (state_reg == tws_pkg::TWS_MACK && scl_rise && sda_f) begin
                  state_next = tws_pkg::TWS_WAIT; // see RL15, RL21
               end else if (scl_fall) begin
                  bit_next = 4'h0;
                  if (rd_reg) begin
                     state_next = tws_pkg::TWS_TX; // see RL20
                     shift_next = {tx_byte[6:0], 1'b0};
                     drv_next   = ~tx_byte[7];
                     dbit_next  = 1'b0;
                  end else begin
                     state_next = tws_pkg::TWS_RX;
                     drv_next   = 1'b0; // see RL2
                  end
               end
            end
            tws_pkg::TWS_TX: begin
               if (scl_fall) begin
                  bit_next = bit_reg + 4'h1;
                  if (bit_reg == 4'h7) begin
                     drv_next   = 1'b0; // see RL8
                     state_next = tws_pkg::TWS_MACK;
                     ovf_next   = ptr_wraps(ptr_reg, ovf_reg);
                     ptr_next   = ptr_inc(ptr_reg, ovf_reg); // see RL23
                  end else begin
                     drv_next   = ~shift_reg[7]; // see RL2, RL3
                     shift_next = {shift_reg[6:0], 1'b0};
                  end
               end
            end
            default: begin
               state_next = tws_pkg::TWS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg   <= tws_pkg::TWS_IDLE;
         bit_reg     <= 4'h0;
         shift_reg   <= 8'h00;
         ptr_reg     <= tws_pkg::PTR_RESET;
         ptr_ld_reg  <= 1'b0;
         rd_reg      <= 1'b0;
         hi_reg      <= 8'h00;
         hi_ok_reg   <= 1'b0;
         ovf_reg     <= 1'b0;
         drv_reg     <= 1'b0;
         dbit_reg    <= 1'b0;
         bus_busy    <= 1'b0;
         reg_wr_en   <= 1'b0;
         reg_wr_addr <= 8'h00;
         reg_wr_data <= 16'h0000;
      end else begin
         state_reg   <= state_next;
         bit_reg     <= bit_next;
         shift_reg   <= shift_next;
         ptr_reg     <= ptr_next;
         ptr_ld_reg  <= ptr_ld_next;
         rd_reg      <= rd_next;
         hi_reg      <= hi_next;
         hi_ok_reg   <= hi_ok_next;
         ovf_reg     <= ovf_next;
         drv_reg     <= drv_next;
         dbit_reg    <= dbit_next;
         bus_busy    <= busy_next;
         reg_wr_en   <= wr_en_next;
         reg_wr_addr <= wr_addr_next;
         reg_wr_data <= wr_data_next;
      end
   end

   // open drain: only ever pull low, enable active low
   always_comb begin
      sda_o       = dbit_reg;
      sda_oe_n    = ~drv_reg; // see RL2
      reg_addr    = ptr_reg;
      reg_rd_addr = ptr_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   a_open_drain_low: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL2
      !sda_oe_n |-> !sda_o) else $error("driven data line not low");
   a_stop_to_idle: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL22
      stop_det |=> state_reg == tws_pkg::TWS_IDLE && !bus_busy)
      else $error("stop did not idle");
   a_start_to_addr: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL5
      start_det && !stop_det |=> state_reg == tws_pkg::TWS_ADDR && bus_busy && sda_oe_n)
      else $error("start not taken");
   a_addr_match_ack: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL12
      state_reg == tws_pkg::TWS_ADDR && scl_fall && bit_reg == tws_pkg::BIT_ACK
      && !start_det && !stop_det && shift_reg[7:1] == 7'h36 |=> !sda_oe_n)
      else $error("address not acked");
   a_addr_miss: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL13
      state_reg == tws_pkg::TWS_ADDR && scl_fall && bit_reg == tws_pkg::BIT_ACK
      && !start_det && !stop_det && shift_reg[7:1] != 7'h36
      |=> state_reg == tws_pkg::TWS_WAIT && sda_oe_n)
      else $error("foreign address acked");
   a_ack_held: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL7
      state_reg == tws_pkg::TWS_ACK && scl_f && !stop_det && !start_det |=> !sda_oe_n)
      else $error("ack released while clock high");
   a_stable_high: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL3
      scl_f && scl_d_reg && !start_det && !stop_det |=> $stable(sda_oe_n) || !scl_d_reg)
      else $error("data changed while clock high");
   a_write_limit: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL24
      reg_wr_en |-> reg_wr_addr <= 8'h4E && !reg_wr_addr[0])
      else $error("write beyond limit or odd");
   a_write_pulse: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL25
      reg_wr_en |=> !reg_wr_en) else $error("write longer than one cycle");
   a_mack_release: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL21
      state_reg == tws_pkg::TWS_MACK |-> sda_oe_n)
      else $error("line driven in master ack slot");
   a_nack_release: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL21
      state_reg == tws_pkg::TWS_MACK && scl_rise && sda_f && !start_det && !stop_det
      |=> state_reg == tws_pkg::TWS_WAIT && sda_oe_n)
      else $error("master nack did not end read");
   a_ptr_load: assert property (@(posedge sys_clk) disable iff (!nrst) // see RL18
      state_reg == tws_pkg::TWS_RX && scl_fall && bit_reg == tws_pkg::BIT_ACK && !ptr_ld_reg
      && !start_det && !stop_det |=> reg_addr == $past(shift_reg))
      else $error("pointer byte not loaded");

   c_write: cover property (@(posedge sys_clk) disable iff (!nrst) reg_wr_en);
   c_ack_write: cover property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == tws_pkg::TWS_ACK && !rd_reg);
   c_read: cover property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == tws_pkg::TWS_TX);
   c_restart: cover property (@(posedge sys_clk) disable iff (!nrst) bus_busy && start_det);
   c_nack_end: cover property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == tws_pkg::TWS_MACK && scl_rise && sda_f);
endmodule
`default_nettype wire

// ### tws_master_model.sv
// behavioural bus master that drives the serial clock and data lines
`default_nettype none
module tws_master_model (
   input  wire logic sys_clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_drv
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tk(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // start or repeated start, from idle or from clock low
   task automatic start_cond();
      tk(2);
      sda_drv = 1'b1;
      tk(3);
      scl = 1'b1;
      tk(4);
      sda_drv = 1'b0;
      tk(4);
      scl = 1'b0;
   endtask

   task automatic stop_cond();
      tk(2);
      sda_drv = 1'b0;
      tk(3);
      scl = 1'b1;
      tk(4);
      sda_drv = 1'b1;
      tk(4);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one clock: data set mid-low, low held 5 cycles, sampled at end of high
   task automatic send_bit(input logic b, output logic got);
      tk(2);
      sda_drv = b;
      tk(3);
      scl = 1'b1;
      tk(3);
      got = sda;
      scl = 1'b0;
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) send_bit(d[i], g);
      send_bit(1'b1, g);
      ack = ~g;
   endtask

   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         send_bit(1'b1, g);
         d[i] = g;
      end
      send_bit(~ack, g);
   endtask
endmodule
`default_nettype wire

// ### two_wire_register_slave_test.sv
// self-checking bench for the two-wire register slave
`default_nettype none
module two_wire_register_slave_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk = 1'b0;
   logic        nrst;
   logic        scl;
   logic        sda_drv;
   wire logic   sda;
   logic        sda_o;
   logic        sda_oe_n;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_rd_addr;
   logic [7:0]  reg_rd_data;
   logic [7:0]  reg_wr_addr;
   logic [15:0] reg_wr_data;
   logic        reg_wr_en;
   logic        bus_busy;
   logic [23:0] wr_q[$];
   int          failures = 0;
   int          total_checks = 0;
   int          cycles = 0;

   always #12.5 sys_clk = ~sys_clk;

   // open-drain wire with pull-up
   assign sda = sda_drv & (sda_oe_n | sda_o);
   assign reg_rd_data = reg_rd_addr ^ 8'hA5;

   tws_master_model mst (
      .sys_clk (sys_clk),
      .sda     (sda),
      .scl     (scl),
      .sda_drv (sda_drv)
   );

   tws_slave uut (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .scl_i       (scl),
      .sda_i       (sda),
      .sda_o       (sda_o),
      .sda_oe_n    (sda_oe_n),
      .reg_addr    (reg_addr),
      .reg_rd_addr (reg_rd_addr),
      .reg_rd_data (reg_rd_data),
      .reg_wr_addr (reg_wr_addr),
      .reg_wr_data (reg_wr_data),
      .reg_wr_en   (reg_wr_en),
      .bus_busy    (bus_busy)
   );

   always @(posedge sys_clk) begin
      if (reg_wr_en === 1'b1) wr_q.push_back({reg_wr_addr, reg_wr_data});
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         failures++;
         final_report();
      end
   end

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic [7:0] d);
      logic a;
      mst.write_byte(d, a);
      check({23'h0, a}, 24'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_probe();
      logic a;
      mst.start_cond();
      mst.tk(4);
      check({23'h0, bus_busy}, 24'h1);
      wb(8'h6C);
      mst.stop_cond();
      mst.tk(4);
      check({23'h0, bus_busy}, 24'h0);
      mst.start_cond();
      mst.write_byte(8'h6E, a);
      check({23'h0, a}, 24'h0);
      mst.stop_cond();
      mst.start_cond();
      wb(8'h6C);
      mst.stop_cond();
   endtask

   task automatic t_write();
      mst.start_cond();
      wb(8'h6C);
      wb(8'h10);
      wb(8'h11);
      wb(8'h22);
      wb(8'h33);
      wb(8'h44);
      wb(8'h55);
      mst.stop_cond();
      mst.tk(4);
      check(24'(wr_q.size()), 24'h2);
      check(wr_q[0], {8'h10, 16'h1122});
      check(wr_q[1], {8'h12, 16'h3344});
      check({16'h0, reg_addr}, 24'h15);
      wr_q.delete();
   endtask

   task automatic t_limit();
      logic a;
      mst.start_cond();
      wb(8'h6C);
      wb(8'h4E);
      wb(8'h01);
      wb(8'h02);
      mst.write_byte(8'h03, a);
      mst.write_byte(8'h04, a);
      mst.stop_cond();
      mst.tk(4);
      check(24'(wr_q.size()), 24'h1);
      check(wr_q[0], {8'h4E, 16'h0102});
      wr_q.delete();
   endtask

   task automatic t_read();
      logic [7:0] d;
      mst.start_cond();
      wb(8'h6C);
      wb(8'hFE);
      mst.start_cond();
      wb(8'h6D);
      mst.read_byte(1'b1, d);
      check({16'h0, d}, {16'h0, 8'hFE ^ 8'hA5});
      mst.read_byte(1'b1, d);
      check({16'h0, d}, {16'h0, 8'hFF ^ 8'hA5});
      mst.read_byte(1'b0, d);
      check({16'h0, d}, 24'hFF);
      mst.tk(2);
      check({23'h0, sda_oe_n}, 24'h1);
      mst.stop_cond();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      mst.tk(8);
      t_probe();
      t_write();
      t_limit();
      t_read();
      final_report();
   end
endmodule
`default_nettype wire
